// ==== pccl_host.sv ====
// Purpose: serial bus host model driving the register bank port
// Assumes: open drain data line with pull-up, bus driven on falling sys clock
// Notes:   each bus bit spans three quarter steps of HALF clocks
`timescale 1ns/100ps
module pccl_host (
    input  wire logic sys_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    localparam int HALF = 4;
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end
    // ------------------------------------------------------------
    // bus conditions and bits
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // also serves as repeated start: data released while clock low
    task automatic start_cond();
        sda_oe_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_oe_o = 1'b1;
        tick(HALF);
        scl_o = 1'b0;
        tick(HALF);
    endtask
    task automatic stop_cond();
        sda_oe_o = 1'b1;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_oe_o = 1'b0;
        tick(HALF);
    endtask
    // data set while clock low, sampled near the end of clock high
    task automatic bit_io(input logic b, output logic s);
        sda_oe_o = ~b;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        s = sda_i;
        scl_o = 1'b0;
        tick(HALF);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule

// ==== pccl_pkg.sv ====
// Purpose: shared constants and types for the phase control register bank
// Assumes: 10 MHz system clock, byte-wide registers behind a two-wire serial port
// Notes:   register offsets are byte addresses on the serial port
package pccl_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CURRENT_MONITOR_PIN     = 8'h26;
    localparam logic [7:0] OFS_LOCK     = 8'h2A;
    localparam logic [7:0] OFS_RAMP     = 8'h2B;
    localparam logic [7:0] OFS_OC_STAT  = 8'h2D;
    localparam logic [7:0] OFS_OC_CFG   = 8'h2E;
    localparam logic [7:0] OFS_FREQ     = 8'h2F;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         LOCK_BIT     = 0;
    localparam int         THR_HI       = 3;
    localparam int         THR_LO       = 2;
    localparam int         DLY_HI       = 1;
    localparam int         DLY_LO       = 0;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [3:0] RST_CODE     = 4'h0;
    localparam logic [7:0] RD_UNMAPPED  = 8'h00;
    // ------------------------------------------------------------
    // timing and levels
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned MS_PER_S    = 1000;
    localparam int unsigned DLY_MS_0    = 4;
    localparam int unsigned DLY_MS_1    = 6;
    localparam int unsigned DLY_MS_2    = 8;
    localparam int unsigned DLY_MS_3    = 10;
    localparam logic [7:0]  THR_MV_0    = 8'h41;
    localparam logic [7:0]  THR_MV_1    = 8'h4B;
    localparam logic [7:0]  THR_MV_2    = 8'h64;
    localparam logic [7:0]  THR_MV_3    = 8'h86;
    localparam int          CNT_W       = 20;
    localparam logic [6:0]  DEV_ADDR    = 7'h20;
    localparam logic [3:0]  BITS_BYTE   = 4'h8;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pccl_wr_t;

    typedef enum logic [3:0] {
        SL_IDLE, SL_ADDR, SL_ACK_A, SL_PTR, SL_ACK_P,
        SL_WDATA, SL_ACK_W, SL_RDATA, SL_RACK, SL_RLOAD
    } pccl_sl_state_t;
endpackage

// ==== pccl_regs.sv ====
// Purpose: current readback, limit lock, ramp and overcurrent strap registers
// Assumes: rst_i is asserted only by a power cycle; inputs synchronous
// Notes:   serial slave instantiated here gives the host access
`timescale 1ns/100ps
module pccl_regs #(
    parameter int unsigned NUM_PHASES = 8,
    parameter int unsigned MS_CYC     = pccl_pkg::CLK_HZ / pccl_pkg::MS_PER_S,
    parameter logic [6:0]  DEV_ADDR   = pccl_pkg::DEV_ADDR
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        clk_en_i,
    input  wire logic                        scl_i,
    input  wire logic                        sda_i,
    output logic                             sda_o,
    output logic                             sda_oe_o,
    input  wire logic                        enable_i,
    input  wire logic [7:0]                  adc_current_i,
    input  wire logic [3:0]                  ramp_strap_i,
    input  wire logic [3:0]                  oc_strap_i,
    input  wire logic [3:0]                  freq_strap_i,
    input  wire logic                        oc_sel_a_i,
    input  wire logic                        oc_sel_b_i,
    input  wire logic [NUM_PHASES-1:0][7:0]  phase_sense_mv_i,
    output logic [3:0]                       ramp_code_o,
    output logic [3:0]                       freq_code_o,
    output logic [1:0]                       thr_code_o,
    output logic [1:0]                       dly_code_o,
    output logic [NUM_PHASES-1:0]            phase_trip_o,
    output logic                             latch_off_o,
    output logic                             lock_o
);
    import pccl_pkg::*;

    initial begin
        if (NUM_PHASES < 1 || NUM_PHASES > 8) $error("NUM_PHASES out of range");
        if (MS_CYC < 1 || 64'(MS_CYC) * DLY_MS_3 >= (64'd1 << CNT_W)) $error("MS_CYC too big");
    end

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] thr_mv(input logic [1:0] code);
        case (code)
            2'h0:    thr_mv = THR_MV_0;
            2'h1:    thr_mv = THR_MV_1;
            2'h2:    thr_mv = THR_MV_2;
            default: thr_mv = THR_MV_3;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] dly_cyc(input logic [1:0] code);
        case (code)
            2'h0:    dly_cyc = CNT_W'(DLY_MS_0 * MS_CYC);
            2'h1:    dly_cyc = CNT_W'(DLY_MS_1 * MS_CYC);
            2'h2:    dly_cyc = CNT_W'(DLY_MS_2 * MS_CYC);
            default: dly_cyc = CNT_W'(DLY_MS_3 * MS_CYC);
        endcase
    endfunction

    // ------------------------------------------------------------
    // serial access
    // ------------------------------------------------------------
    pccl_wr_t   wr;
    logic [7:0] rd_addr, rdata;

    pccl_serial #(
        .DEV_ADDR (DEV_ADDR)
    ) u_serial (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .clk_en_i  (clk_en_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_o     (sda_o),
        .sda_oe_o  (sda_oe_o),
        .rdata_i   (rdata),
        .rd_addr_o (rd_addr),
        .wr_o      (wr)
    );

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] current_monitor_pin_q, current_monitor_pin_d;
    logic       lock_q, lock_d, en_q, en_rise;
    logic [3:0] ramp_q, ramp_d, ocst_q, ocst_d, ocfg_q, ocfg_d, freq_q, freq_d;
    logic       use_cfg;
    logic [3:0] oc_act;

    assign en_rise = enable_i & ~en_q;

    always_comb begin
        current_monitor_pin_d = adc_current_i;
        lock_d = lock_q;
        ocfg_d = ocfg_q;
        ramp_d = ramp_q;
        ocst_d = ocst_q;
        freq_d = freq_q;
        if (wr.wr && wr.addr == OFS_LOCK && wr.wdata[LOCK_BIT]) begin
            lock_d = 1'b1;
        end
        if (wr.wr && wr.addr == OFS_OC_CFG && !lock_q) begin
            ocfg_d = wr.wdata[THR_HI:DLY_LO];
        end
        if (en_rise) begin
            ramp_d = ramp_strap_i;
            ocst_d = oc_strap_i;
            freq_d = freq_strap_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            current_monitor_pin_q <= RST_BYTE;
            lock_q <= 1'b0;
            ocfg_q <= RST_CODE;
            ramp_q <= RST_CODE;
            ocst_q <= RST_CODE;
            freq_q <= RST_CODE;
            en_q   <= 1'b0;
        end else if (clk_en_i) begin
            current_monitor_pin_q <= current_monitor_pin_d;
            lock_q <= lock_d;
            ocfg_q <= ocfg_d;
            ramp_q <= ramp_d;
            ocst_q <= ocst_d;
            freq_q <= freq_d;
            en_q   <= enable_i;
        end
    end

    // read mux, reserved bits zero
    always_comb begin
        case (rd_addr)
            OFS_CURRENT_MONITOR_PIN:    rdata = current_monitor_pin_q;
            OFS_LOCK:    rdata = {7'h00, lock_q};
            OFS_RAMP:    rdata = {4'h0, ramp_q};
            OFS_OC_STAT: rdata = {4'h0, ocst_q};
            OFS_OC_CFG:  rdata = {4'h0, ocfg_q};
            OFS_FREQ:    rdata = {4'h0, freq_q};
            default:     rdata = RD_UNMAPPED;
        endcase
    end

    // ------------------------------------------------------------
    // overcurrent protection
    // ------------------------------------------------------------
    assign use_cfg     = oc_sel_a_i & oc_sel_b_i;
    assign oc_act      = use_cfg ? ocfg_q : ocst_q;
    assign thr_code_o  = oc_act[THR_HI:THR_LO];
    assign dly_code_o  = oc_act[DLY_HI:DLY_LO];
    assign ramp_code_o = ramp_q;
    assign freq_code_o = freq_q;
    assign lock_o      = lock_q;

    for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
        assign phase_trip_o[p] = phase_sense_mv_i[p] > thr_mv(thr_code_o);
    end

    logic [CNT_W-1:0] tcnt_q, tcnt_d;
    logic             latch_q, latch_d;

    always_comb begin
        tcnt_d  = '0;
        latch_d = latch_q;
        if (!enable_i) begin
            latch_d = 1'b0;
        end else if (|phase_trip_o && !latch_q) begin
            tcnt_d = tcnt_q + 1'b1;
            if (tcnt_d >= dly_cyc(dly_code_o)) begin
                latch_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tcnt_q  <= '0;
            latch_q <= 1'b0;
        end else if (clk_en_i) begin
            tcnt_q  <= tcnt_d;
            latch_q <= latch_d;
        end
    end

    assign latch_off_o = latch_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i || !clk_en_i);

    sequence en_rise_s;
        enable_i && !en_q;
    endsequence
    sequence lock_wr_s;
        wr.wr && wr.addr == OFS_LOCK && wr.wdata[LOCK_BIT];
    endsequence

    lock_set_a: assert property (lock_wr_s |=> lock_o)
        else $error("lock write did not engage lock");
    lock_sticky_a: assert property (lock_o |=> lock_o)
        else $error("lock released");
    cfg_frozen_a: assert property (lock_q ##1 clk_en_i |-> $stable(ocfg_q))
        else $error("locked config changed");
    current_monitor_pin_track_a: assert property (clk_en_i ##1 clk_en_i |-> current_monitor_pin_q == $past(adc_current_i))
        else $error("current readback stale");
    ramp_cap_a: assert property (en_rise_s |=> ramp_code_o == $past(ramp_strap_i))
        else $error("ramp strap not captured");
    ramp_hold_a: assert property (!en_rise |=> $stable(ramp_q))
        else $error("ramp code changed without enable edge");
    oc_cap_a: assert property (en_rise_s |=> ocst_q == $past(oc_strap_i))
        else $error("overcurrent strap not captured");
    freq_cap_a: assert property (en_rise_s |=> freq_code_o == $past(freq_strap_i))
        else $error("frequency strap not captured");
    src_sel_a: assert property (use_cfg |-> {thr_code_o, dly_code_o} == ocfg_q)
        else $error("config not applied");
    src_strap_a: assert property (!use_cfg |-> {thr_code_o, dly_code_o} == ocst_q)
        else $error("strap not applied");
    latch_time_a: assert property ($rose(latch_q) |-> tcnt_q >= $past(dly_cyc(dly_code_o)))
        else $error("latch-off before delay");
    trip_thr_a: assert property (phase_trip_o[0] == (phase_sense_mv_i[0] > (thr_code_o[1] ?
        (thr_code_o[0] ? THR_MV_3 : THR_MV_2) : (thr_code_o[0] ? THR_MV_1 : THR_MV_0))))
        else $error("trip level wrong");
endmodule

// ==== pccl_regs_bench.sv ====
// Purpose: self-checking bench for the phase control register bank
// Assumes: host model owns the serial port; millisecond shortened to 10 clocks
// Notes:   inputs change on the falling clock edge
`timescale 1ns/100ps
module pccl_regs_bench;
    import pccl_pkg::*;
    localparam int unsigned NPH = 8;
    localparam int unsigned MSC = 10;
    logic                sys_clk_i = 1'b0;
    logic                rst_i     = 1'b1;
    logic                clk_en    = 1'b1;
    logic                k;
    logic [7:0]          rd0;
    logic [7:0]          rd1;
    logic                enable_i  = 1'b0;
    logic [7:0]          adc       = 8'h00;
    logic [3:0]          ramp_s    = 4'h0;
    logic [3:0]          oc_s      = 4'h0;
    logic [3:0]          freq_s    = 4'h0;
    logic                sel_a     = 1'b0;
    logic                sel_b     = 1'b0;
    logic [NPH-1:0][7:0] sense     = '0;
    logic                scl;
    logic                host_oe;
    logic                dev_sda;
    logic                dev_oe;
    logic                latch;
    logic                lock;
    logic [3:0]          ramp_c;
    logic [3:0]          freq_c;
    logic [1:0]          thr_c;
    logic [1:0]          dly_c;
    logic [NPH-1:0]      trip;
    logic [3:0]          c;
    int                  n;
    int                  bad_count   = 0;
    int                  check_count = 0;
    logic [7:0]          thr_mv [4]  = '{8'h41, 8'h4B, 8'h64, 8'h86};
    int                  dly_ms [4]  = '{4, 6, 8, 10};
    wire                 sda         = ~host_oe & ~(dev_oe & ~dev_sda);

    always #50 sys_clk_i = ~sys_clk_i;

    pccl_host u_pccl_host (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));

    pccl_regs #(.NUM_PHASES(NPH), .MS_CYC(MSC)) u_pccl_regs (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .scl_i(scl), .sda_i(sda),
        .sda_o(dev_sda), .sda_oe_o(dev_oe), .enable_i(enable_i), .adc_current_i(adc),
        .ramp_strap_i(ramp_s), .oc_strap_i(oc_s), .freq_strap_i(freq_s),
        .oc_sel_a_i(sel_a), .oc_sel_b_i(sel_b), .phase_sense_mv_i(sense),
        .ramp_code_o(ramp_c), .freq_code_o(freq_c), .thr_code_o(thr_c), .dly_code_o(dly_c),
        .phase_trip_o(trip), .latch_off_o(latch), .lock_o(lock)
    );
    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic clk(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k0, k1, k2;
        u_pccl_host.start_cond();
        u_pccl_host.send_byte({DEV_ADDR, 1'b0}, k0);
        u_pccl_host.send_byte(a, k1);
        u_pccl_host.send_byte(d, k2);
        u_pccl_host.stop_cond();
        check({5'h00, k0, k1, k2}, 8'h07);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic       k0, k1, k2;
        logic [7:0] d;
        u_pccl_host.start_cond();
        u_pccl_host.send_byte({DEV_ADDR, 1'b0}, k0);
        u_pccl_host.send_byte(a, k1);
        u_pccl_host.start_cond();
        u_pccl_host.send_byte({DEV_ADDR, 1'b1}, k2);
        u_pccl_host.recv_byte(1'b1, d);
        u_pccl_host.stop_cond();
        check({5'h00, k0, k1, k2}, 8'h07);
        check(d, e);
    endtask
    task automatic en_pulse();
        enable_i = 1'b0;
        clk(2);
        enable_i = 1'b1;
        clk(2);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        clk(12);
        rst_i = 1'b0;
        clk(2);
        rd_chk(8'h2A, 8'h00);
        rd_chk(8'h2E, 8'h00);
        rd_chk(8'h2C, 8'h00);
        u_pccl_host.start_cond();
        u_pccl_host.send_byte({DEV_ADDR ^ 7'h01, 1'b0}, k);
        u_pccl_host.stop_cond();
        check({7'h00, k}, 8'h00);
        adc = 8'hFF;
        clk(2);
        rd_chk(8'h26, 8'hFF);
        adc = 8'h5A;
        clk(2);
        rd_chk(8'h26, 8'h5A);
        for (int i = 0; i < 4; i++) begin
            c      = 4'(5 * i);
            ramp_s = c;
            freq_s = ~c;
            oc_s   = c ^ 4'h3;
            en_pulse();
            ramp_s = ~c;
            freq_s = c;
            oc_s   = ~c;
            clk(2);
            check({4'h0, ramp_c}, {4'h0, c});
            check({4'h0, freq_c}, {4'h0, ~c});
            check({4'h0, thr_c, dly_c}, {4'h0, c ^ 4'h3});
            rd_chk(8'h2B, {4'h0, c});
            rd_chk(8'h2D, {4'h0, c ^ 4'h3});
            rd_chk(8'h2F, {4'h0, ~c});
        end
        clk_en = 1'b0;
        ramp_s = 4'h6;
        en_pulse();
        clk_en = 1'b1;
        clk(2);
        check({4'h0, ramp_c}, {4'h0, c});
        wr(8'h2E, 8'hF9);
        rd_chk(8'h2E, 8'h09);
        sel_a = 1'b1;
        clk(2);
        check({4'h0, thr_c, dly_c}, {4'h0, c ^ 4'h3});
        sel_a = 1'b0;
        sel_b = 1'b1;
        clk(2);
        check({4'h0, thr_c, dly_c}, {4'h0, c ^ 4'h3});
        sel_a = 1'b1;
        clk(2);
        check({4'h0, thr_c, dly_c}, 8'h09);
        for (int t = 0; t < 4; t++) begin
            sense = '0;
            wr(8'h2E, {4'h0, 2'(t), 2'b00});
            sense    = {NPH{thr_mv[t]}};
            sense[3] = thr_mv[t] + 8'h01;
            clk(1);
            check({6'h00, thr_c}, {6'h00, 2'(t)});
            check(trip, 8'h08);
            sense = '0;
        end
        for (int t = 0; t < 4; t++) begin
            wr(8'h2E, {6'h00, 2'(t)});
            sense[0] = 8'h50;
            n = 0;
            while (latch !== 1'b1 && n < 200) begin
                clk(1);
                n++;
            end
            if (n >= 200) begin
                bad_count++;
                $display("unexpected at %0t: latch-off never came", $time);
                finish_test();
            end
            check({7'h00, n >= dly_ms[t] * MSC - 1 && n <= dly_ms[t] * MSC + 2}, 8'h01);
            sense = '0;
            enable_i = 1'b0;
            clk(2);
            check({7'h00, latch}, 8'h00);
            enable_i = 1'b1;
            clk(2);
        end
        wr(8'h2E, 8'h06);
        wr(8'h2A, 8'h01);
        check({7'h00, lock}, 8'h01);
        rd_chk(8'h2A, 8'h01);
        wr(8'h2E, 8'h09);
        rd_chk(8'h2E, 8'h06);
        u_pccl_host.start_cond();
        u_pccl_host.send_byte({DEV_ADDR, 1'b0}, k);
        u_pccl_host.send_byte(8'h2D, k);
        u_pccl_host.start_cond();
        u_pccl_host.send_byte({DEV_ADDR, 1'b1}, k);
        u_pccl_host.recv_byte(1'b0, rd0);
        u_pccl_host.recv_byte(1'b1, rd1);
        u_pccl_host.stop_cond();
        check(rd0, 8'h00);
        check(rd1, 8'h06);
        check({6'h00, thr_c}, 8'h01);
        wr(8'h2A, 8'h00);
        en_pulse();
        check({7'h00, lock}, 8'h01);
        rd_chk(8'h2E, 8'h06);
        rst_i = 1'b1;
        clk(2);
        rst_i = 1'b0;
        clk(2);
        check({7'h00, lock}, 8'h00);
        wr(8'h2E, 8'h0A);
        rd_chk(8'h2E, 8'h0A);
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge sys_clk_i);
        bad_count++;
        $display("unexpected at %0t: run timed out", $time);
        finish_test();
    end
endmodule

// ==== pccl_serial.sv ====
// Purpose: two-wire serial slave giving byte writes and pointer reads
// Assumes: scl and sda inputs synchronous to sys_clk_i
// Notes:   write: address, pointer, data...; read continues from the pointer
`timescale 1ns/100ps
module pccl_serial #(
    parameter logic [6:0] DEV_ADDR = pccl_pkg::DEV_ADDR
) (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    input  wire logic               clk_en_i,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe_o,
    input  wire logic [7:0]         rdata_i,
    output logic [7:0]              rd_addr_o,
    output pccl_pkg::pccl_wr_t      wr_o
);
    import pccl_pkg::*;

    pccl_sl_state_t st_q, st_d;
    logic [3:0]     cnt_q, cnt_d;
    logic [7:0]     sh_q, sh_d, ptr_q, ptr_d;
    logic           rw_q, rw_d, oe_q, oe_d, scl_q, sda_q;
    pccl_wr_t       wr_q, wr_d;
    logic           start, stop, rise, fall;

    assign start     = scl_i & scl_q & sda_q & ~sda_i;
    assign stop      = scl_i & scl_q & ~sda_q & sda_i;
    assign rise      = scl_i & ~scl_q;
    assign fall      = ~scl_i & scl_q;
    assign sda_o     = 1'b0;
    assign sda_oe_o  = oe_q;
    assign rd_addr_o = ptr_q;
    assign wr_o      = wr_q;

    // ------------------------------------------------------------
    // protocol sequencing
    // ------------------------------------------------------------
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        sh_d  = sh_q;
        ptr_d = ptr_q;
        rw_d  = rw_q;
        oe_d  = oe_q;
        wr_d  = '{wr: 1'b0, addr: ptr_q, wdata: sh_q};
        if (start) begin
            st_d  = SL_ADDR;
            cnt_d = '0;
            oe_d  = 1'b0;
        end else if (stop) begin
            st_d = SL_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                SL_ADDR, SL_PTR, SL_WDATA: begin
                    if (rise) begin
                        sh_d  = {sh_q[6:0], sda_i};
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall && cnt_q == BITS_BYTE) begin
                        oe_d = 1'b1;
                        if (st_q == SL_ADDR) begin
                            rw_d = sh_q[0];
                            st_d = SL_ACK_A;
                            if (sh_q[7:1] != DEV_ADDR) begin
                                st_d = SL_IDLE;
                                oe_d = 1'b0;
                            end
                        end else if (st_q == SL_PTR) begin
                            ptr_d = sh_q;
                            st_d  = SL_ACK_P;
                        end else begin
                            wr_d = '{wr: 1'b1, addr: ptr_q, wdata: sh_q};
                            st_d = SL_ACK_W;
                        end
                    end
                end
                SL_ACK_A: begin
                    if (fall) begin
                        cnt_d = '0;
                        oe_d  = 1'b0;
                        st_d  = SL_PTR;
                        if (rw_q) begin
                            sh_d = rdata_i;
                            oe_d = ~rdata_i[7];
                            st_d = SL_RDATA;
                        end
                    end
                end
                SL_ACK_P, SL_ACK_W: begin
                    if (fall) begin
                        cnt_d = '0;
                        oe_d  = 1'b0;
                        st_d  = SL_WDATA;
                        if (st_q == SL_ACK_W) begin
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                SL_RDATA: begin
                    if (rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall) begin
                        if (cnt_q == BITS_BYTE) begin
                            oe_d  = 1'b0;
                            ptr_d = ptr_q + 8'h01;
                            st_d  = SL_RACK;
                        end else begin
                            oe_d = ~sh_q[3'(7 - cnt_q)];
                        end
                    end
                end
                SL_RACK: begin
                    if (rise) begin
                        st_d = sda_i ? SL_IDLE : SL_RLOAD;
                    end
                end
                SL_RLOAD: begin
                    if (fall) begin
                        sh_d  = rdata_i;
                        oe_d  = ~rdata_i[7];
                        cnt_d = '0;
                        st_d  = SL_RDATA;
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q  <= SL_IDLE;
            cnt_q <= '0;
            sh_q  <= RST_BYTE;
            ptr_q <= RST_BYTE;
            rw_q  <= 1'b0;
            oe_q  <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            wr_q  <= '0;
        end else if (clk_en_i) begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            sh_q  <= sh_d;
            ptr_q <= ptr_d;
            rw_q  <= rw_d;
            oe_q  <= oe_d;
            scl_q <= scl_i;
            sda_q <= sda_i;
            wr_q  <= wr_d;
        end else begin
            wr_q.wr <= 1'b0;
        end
    end
endmodule
